// File: logic/jtp_tx_test_align.sv
// transmit link test selection, alignment start delay and register slave
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "jtp_params.svh"

module jtp_tx_test_align
#(
  parameter logic [127:0] RPAT_SEQ   = 128'h0123456789ABCDEF0123456789ABCDEF, // modified random pattern octets
  parameter logic [127:0] JSPAT_SEQ  = 128'h00FF00FF0F0F0F0F3333333355555555, // scrambled jitter pattern octets
  parameter logic [127:0] JTSPAT_SEQ = 128'h55AA55AA00FF00FFF0F0F0F033CC33CC  // tolerance pattern octets
)
(
  input  wire logic                    i_ref_clk,         // 200 MHz sample clock
  input  wire logic                    i_rst_b,           // synchronous reset, active low
  input  wire logic [12:0]             i_avs_address,     // byte address
  input  wire logic                    i_avs_read,        // read request
  input  wire logic                    i_avs_write,       // write request
  input  wire logic [31:0]             i_avs_writedata,   // write data
  input  wire logic [3:0]              i_avs_byteenable,  // byte lanes
  output logic      [31:0]             o_avs_readdata,    // read data
  output logic                         o_avs_waitrequest, // stall
  input  wire logic                    i_sync_request_b,  // receiver sync request, active low
  input  wire logic                    i_sysref,          // system reference pulse
  input  wire logic [15:0]             i_sample,          // live converter word
  output jtp_pkg::jtp_lane_t           o_lane_q,          // lane octets and control flags
  output logic                         o_mf_boundary_q    // multiframe boundary marker
);

  // ***************************************************************
  // register state
  // ***************************************************************
  logic [7:0]  link_ctrl_q;   // alignment delay and link test
  logic [7:0]  link_ctrl_d;
  logic [7:0]  pat_sel_q;     // sample pattern select
  logic [7:0]  pat_sel_d;
  logic [7:0]  user_lo_q;     // user word low byte
  logic [7:0]  user_lo_d;
  logic [7:0]  user_hi_q;     // user word high byte
  logic [7:0]  user_hi_d;
  logic [4:0]  mf_preset_q;   // multiframe phase preset
  logic [4:0]  mf_preset_d;
  logic [4:0]  mf_frames_q;   // frames per multiframe minus one
  logic [4:0]  mf_frames_d;
  logic        ack_q;         // one-cycle answer strobe
  logic        ack_d;
  logic [31:0] rdata_d;
  logic [10:0] idx;           // register index
  logic        req;

  // ***************************************************************
  // link state
  // ***************************************************************
  jtp_pkg::jtp_link_st_t st_q;   // link progress
  jtp_pkg::jtp_link_st_t st_d;
  logic [4:0]  mf_cnt_q;          // multiframe phase counter
  logic [4:0]  mf_cnt_d;
  logic [3:0]  bnd_cnt_q;         // boundaries seen since release
  logic [3:0]  bnd_cnt_d;
  logic [2:0]  ilas_mf_q;         // multiframes of alignment sent
  logic [2:0]  ilas_mf_d;
  logic [3:0]  seq_ptr_q;         // test sequence position
  logic [3:0]  seq_ptr_d;
  logic        mf_bnd;            // this cycle closes a multiframe
  logic [3:0]  delay;             // alignment start delay field
  jtp_pkg::jtp_ltest_t ltest;     // active link test code
  jtp_pkg::jtp_lane_t  lane_d;
  logic [15:0] pat_word;          // generator output

  // pick one octet pair from a packed sequence table
  function automatic logic [15:0] seq_pair(input logic [127:0] tbl, input logic [3:0] p);
    logic [6:0] base;
    base = {p[2:0], 4'h0};
    return tbl[base +: 16];
  endfunction

  // ***************************************************************
  // avalon slave: one wait cycle, then answer
  // ***************************************************************
  assign req               = i_avs_read | i_avs_write;
  assign idx               = i_avs_address[12:2];
  assign o_avs_waitrequest = req & ~ack_q;

  // register next values and read mux
  always_comb
  begin
    link_ctrl_d = link_ctrl_q;
    pat_sel_d   = pat_sel_q;
    user_lo_d   = user_lo_q;
    user_hi_d   = user_hi_q;
    mf_preset_d = mf_preset_q;
    mf_frames_d = mf_frames_q;
    ack_d       = req & ~ack_q;
    rdata_d     = o_avs_readdata;
    // writes land only at the edge where waitrequest is low
    if (i_avs_write && ack_q && i_avs_byteenable[0])
    begin
      unique case (idx)
        `JTP_IDX_LINK_CTRL: link_ctrl_d = {i_avs_writedata[7:4], 1'b0, i_avs_writedata[2:0]};
        `JTP_IDX_PAT_SEL:   pat_sel_d   = {4'h0, i_avs_writedata[3:0]};
        `JTP_IDX_USER_LO:   user_lo_d   = i_avs_writedata[7:0];
        `JTP_IDX_USER_HI:   user_hi_d   = i_avs_writedata[7:0];
        `JTP_IDX_MF_PRESET: mf_preset_d = i_avs_writedata[4:0];
        `JTP_IDX_MF_FRAMES: mf_frames_d = i_avs_writedata[4:0];
        default:            link_ctrl_d = link_ctrl_q;
      endcase
    end
    // read data is captured one cycle ahead of the answer
    if (ack_d)
    begin
      unique case (idx)
        `JTP_IDX_LINK_CTRL: rdata_d = {24'h000000, link_ctrl_q};
        `JTP_IDX_PAT_SEL:   rdata_d = {24'h000000, pat_sel_q};
        `JTP_IDX_USER_LO:   rdata_d = {24'h000000, user_lo_q};
        `JTP_IDX_USER_HI:   rdata_d = {24'h000000, user_hi_q};
        `JTP_IDX_MF_PRESET: rdata_d = {27'h0000000, mf_preset_q};
        `JTP_IDX_MF_FRAMES: rdata_d = {27'h0000000, mf_frames_q};
        `JTP_IDX_STATUS:    rdata_d = {16'h0000, 3'h0, mf_cnt_q, bnd_cnt_q, 1'b0, i_sync_request_b, st_q};
        default:            rdata_d = 32'h00000000;
      endcase
    end
  end

  // register file flops
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      link_ctrl_q    <= `JTP_RST_LINK_CTRL;
      pat_sel_q      <= `JTP_RST_PAT_SEL;
      user_lo_q      <= `JTP_RST_USER;
      user_hi_q      <= `JTP_RST_USER;
      mf_preset_q    <= 5'(`JTP_RST_MF_PRESET);
      mf_frames_q    <= 5'(`JTP_RST_MF_FRAMES);
      ack_q          <= 1'b0;
      o_avs_readdata <= 32'h00000000;
    end
    else
    begin
      link_ctrl_q    <= link_ctrl_d;
      pat_sel_q      <= pat_sel_d;
      user_lo_q      <= user_lo_d;
      user_hi_q      <= user_hi_d;
      mf_preset_q    <= mf_preset_d;
      mf_frames_q    <= mf_frames_d;
      ack_q          <= ack_d;
      o_avs_readdata <= rdata_d;
    end
  end

  // ***************************************************************
  // sample pattern generator
  // ***************************************************************
  jtp_pattern_gen u_pat
  (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_sel     (pat_sel_q[3:0]),
    .i_user    ({user_hi_q, user_lo_q}),
    .i_sample  (i_sample),
    .o_word_q  (pat_word)
  );

  // ***************************************************************
  // link control decode
  // ***************************************************************
  assign delay  = link_ctrl_q[`JTP_DELAY_MSB:`JTP_DELAY_LSB];
  // reserved link test codes fall back to normal operation
  assign ltest  = (link_ctrl_q[2:0] == 3'h2 || link_ctrl_q[2:0] == 3'h3 || link_ctrl_q[2:0] == 3'h7)
                  ? jtp_pkg::JTP_LT_NORMAL : jtp_pkg::jtp_ltest_t'(link_ctrl_q[2:0]);
  assign mf_bnd = (mf_cnt_q == mf_frames_q);

  // ***************************************************************
  // multiframe counter, alignment sequencing and lane mux
  // ***************************************************************
  always_comb
  begin
    st_d      = st_q;
    bnd_cnt_d = bnd_cnt_q;
    ilas_mf_d = ilas_mf_q;
    seq_ptr_d = seq_ptr_q + 4'h1;
    lane_d    = '{k: 2'b00, octets: pat_word};
    // phase counter, preset on the reference pulse
    if (i_sysref)
      mf_cnt_d = mf_preset_q;
    else if (mf_bnd)
      mf_cnt_d = 5'h00;
    else
      mf_cnt_d = mf_cnt_q + 5'h01;
    // sync request low always forces code group sync
    if (!i_sync_request_b)
    begin
      st_d      = jtp_pkg::JTP_ST_CGS;
      bnd_cnt_d = 4'h0;
      ilas_mf_d = 3'h0;
    end
    else
    begin
      unique case (st_q)
        jtp_pkg::JTP_ST_CGS:
        begin
          st_d      = jtp_pkg::JTP_ST_WAIT;
          bnd_cnt_d = 4'h0;
        end
        jtp_pkg::JTP_ST_WAIT:
        begin
          // count boundaries; start on boundary number delay plus one
          if (mf_bnd)
          begin
            if (bnd_cnt_q == delay)
              st_d = jtp_pkg::JTP_ST_ILAS;
            else
              bnd_cnt_d = bnd_cnt_q + 4'h1;
          end
        end
        jtp_pkg::JTP_ST_ILAS:
        begin
          if (mf_bnd)
          begin
            ilas_mf_d = ilas_mf_q + 3'h1;
            if (ilas_mf_q == `JTP_ILAS_MFRAMES - 3'h1)
              st_d = jtp_pkg::JTP_ST_DATA;
          end
        end
        jtp_pkg::JTP_ST_DATA:
          st_d = jtp_pkg::JTP_ST_DATA;
      endcase
    end
    // lane octets by state
    unique case (st_q)
      jtp_pkg::JTP_ST_CGS, jtp_pkg::JTP_ST_WAIT:
        lane_d = '{k: 2'b11, octets: {`JTP_K28_5, `JTP_K28_5}};
      jtp_pkg::JTP_ST_ILAS:
      begin
        // start marker opens each multiframe, end marker closes it
        if (mf_cnt_q == 5'h00)
          lane_d = '{k: 2'b10, octets: {`JTP_K28_0, 3'h0, mf_cnt_q}};
        else if (mf_bnd)
          lane_d = '{k: 2'b01, octets: {3'h0, mf_cnt_q, `JTP_K28_3}};
        else
          lane_d = '{k: 2'b00, octets: {3'h0, mf_cnt_q, 5'h00, ilas_mf_q}};
      end
      jtp_pkg::JTP_ST_DATA:
        lane_d = '{k: 2'b00, octets: pat_word};
    endcase
    // link test modes override whatever the link would send
    unique case (ltest)
      jtp_pkg::JTP_LT_D215:
        lane_d = '{k: 2'b00, octets: {`JTP_D21_5, `JTP_D21_5}};
      jtp_pkg::JTP_LT_RPAT:
        lane_d = '{k: 2'b00, octets: seq_pair(RPAT_SEQ, seq_ptr_q)};
      jtp_pkg::JTP_LT_JSPAT:
        lane_d = '{k: 2'b00, octets: seq_pair(JSPAT_SEQ, seq_ptr_q)};
      jtp_pkg::JTP_LT_JTSPAT:
        lane_d = '{k: 2'b00, octets: seq_pair(JTSPAT_SEQ, seq_ptr_q)};
      default:
        lane_d = lane_d;
    endcase
  end

  // link state flops
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      st_q            <= jtp_pkg::JTP_ST_CGS;
      mf_cnt_q        <= 5'h00;
      bnd_cnt_q       <= 4'h0;
      ilas_mf_q       <= 3'h0;
      seq_ptr_q       <= 4'h0;
      o_lane_q        <= '{k: 2'b00, octets: 16'h0000};
      o_mf_boundary_q <= 1'b0;
    end
    else
    begin
      st_q            <= st_d;
      mf_cnt_q        <= mf_cnt_d;
      bnd_cnt_q       <= bnd_cnt_d;
      ilas_mf_q       <= ilas_mf_d;
      seq_ptr_q       <= seq_ptr_d;
      o_lane_q        <= lane_d;
      o_mf_boundary_q <= mf_bnd;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  a_bus_answer: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (req && !ack_q) |=> (ack_q && !o_avs_waitrequest))
    else $error("bus answer not given after one wait cycle");
  a_cgs_chars: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (st_q == jtp_pkg::JTP_ST_CGS && ltest == jtp_pkg::JTP_LT_NORMAL)
    |=> (o_lane_q.k == 2'b11 && o_lane_q.octets == {`JTP_K28_5, `JTP_K28_5}))
    else $error("sync characters missing during sync request");
  a_sync_to_cgs: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !i_sync_request_b |=> (st_q == jtp_pkg::JTP_ST_CGS))
    else $error("sync request did not force code group sync");
  a_ilas_start: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    $rose(st_q == jtp_pkg::JTP_ST_ILAS) |-> ($past(mf_bnd) && $past(bnd_cnt_q) == $past(delay)))
    else $error("alignment started on the wrong boundary");
  a_preset_load: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    i_sysref |=> (mf_cnt_q == $past(mf_preset_q)))
    else $error("phase counter did not load the preset");
  a_d215_stream: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (link_ctrl_q[2:0] == 3'h1) |=> (o_lane_q.octets == {`JTP_D21_5, `JTP_D21_5} && o_lane_q.k == 2'b00))
    else $error("link test did not send D21.5");
  a_reserved_ltest: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (link_ctrl_q[2:0] inside {3'h2, 3'h3, 3'h7} && st_q == jtp_pkg::JTP_ST_DATA)
    |=> (o_lane_q.k == 2'b00 && o_lane_q.octets == $past(pat_word)))
    else $error("reserved link test code was acted on");
  a_ilas_marker: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (st_q == jtp_pkg::JTP_ST_ILAS && mf_cnt_q == 5'h00 && ltest == jtp_pkg::JTP_LT_NORMAL)
    |=> (o_lane_q.k == 2'b10 && o_lane_q.octets[15:8] == `JTP_K28_0))
    else $error("multiframe start marker missing in alignment");
  a_ilas_to_data: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (st_q == jtp_pkg::JTP_ST_ILAS && mf_bnd && ilas_mf_q == 3'h3 && i_sync_request_b)
    |=> (st_q == jtp_pkg::JTP_ST_DATA))
    else $error("alignment sequence did not hand over to data");
  a_pat_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_avs_write && !o_avs_waitrequest && idx == `JTP_IDX_PAT_SEL && i_avs_byteenable[0])
    |=> (pat_sel_q == {4'h0, $past(i_avs_writedata[3:0])}))
    else $error("pattern select write did not land");
  a_rpat_seq: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (link_ctrl_q[2:0] == 3'h4) |=> (o_lane_q.octets == seq_pair(RPAT_SEQ, $past(seq_ptr_q))))
    else $error("random pattern octets wrong");
  a_data_sample: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (st_q == jtp_pkg::JTP_ST_DATA && ltest == jtp_pkg::JTP_LT_NORMAL) |=> (o_lane_q.octets == $past(pat_word)))
    else $error("data state did not carry the sample word");
  c_ilas_seen: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) $rose(st_q == jtp_pkg::JTP_ST_ILAS));
  c_data_seen: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) $rose(st_q == jtp_pkg::JTP_ST_DATA));
  c_jspat_run: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) (ltest == jtp_pkg::JTP_LT_JSPAT) [*4]);

endmodule

// File: logic/jtp_params.svh
// offsets, field positions, reset values and code constants of the test and alignment block
`ifndef JTP_PARAMS_SVH
`define JTP_PARAMS_SVH

// ***************************************************************
// register indexes (byte address is four times the index)
// ***************************************************************
`define JTP_IDX_PAT_SEL      11'h550
`define JTP_IDX_USER_LO      11'h551
`define JTP_IDX_USER_HI      11'h552
`define JTP_IDX_LINK_CTRL    11'h574
`define JTP_IDX_MF_PRESET    11'h578
`define JTP_IDX_MF_FRAMES    11'h58D
`define JTP_IDX_STATUS       11'h5F0

// ***************************************************************
// field positions and reset values
// ***************************************************************
`define JTP_DELAY_MSB        7
`define JTP_DELAY_LSB        4
`define JTP_LTEST_MSB        2
`define JTP_LTEST_LSB        0
`define JTP_RST_LINK_CTRL    8'h00
`define JTP_RST_PAT_SEL      8'h00
`define JTP_RST_MF_PRESET    8'h00
`define JTP_RST_MF_FRAMES    8'h1F
`define JTP_RST_USER         8'h00

// ***************************************************************
// character codes and timing counts
// ***************************************************************
`define JTP_K28_5            8'hBC
`define JTP_K28_0            8'h1C
`define JTP_K28_3            8'h7C
`define JTP_D21_5            8'hB5
`define JTP_ILAS_MFRAMES     3'h4
`define JTP_PN_SEED          31'h7FFFFFFF

`endif

// File: logic/jtp_pkg.sv
// types shared by the test pattern and alignment logic
package jtp_pkg;

  // link layer progress
  typedef enum logic [1:0] {
    JTP_ST_CGS,
    JTP_ST_WAIT,
    JTP_ST_ILAS,
    JTP_ST_DATA
  } jtp_link_st_t;

  // sample pattern selector codes
  typedef enum logic [3:0] {
    JTP_PAT_NORMAL  = 4'h0,
    JTP_PAT_CHECKER = 4'h1,
    JTP_PAT_TOGGLE  = 4'h2,
    JTP_PAT_PN31    = 4'h3,
    JTP_PAT_PN23    = 4'h4,
    JTP_PAT_PN15    = 4'h5,
    JTP_PAT_PN9     = 4'h6,
    JTP_PAT_PN7     = 4'h7,
    JTP_PAT_RAMP    = 4'h8,
    JTP_PAT_USER_R  = 4'hE,
    JTP_PAT_USER_S  = 4'hF
  } jtp_pat_t;

  // link layer test selector codes
  typedef enum logic [2:0] {
    JTP_LT_NORMAL = 3'h0,
    JTP_LT_D215   = 3'h1,
    JTP_LT_RSV2   = 3'h2,
    JTP_LT_RSV3   = 3'h3,
    JTP_LT_RPAT   = 3'h4,
    JTP_LT_JSPAT  = 3'h5,
    JTP_LT_JTSPAT = 3'h6,
    JTP_LT_RSV7   = 3'h7
  } jtp_ltest_t;

  // two octets of one lane per clock, with control-character flags
  typedef struct packed {
    logic [1:0]  k;
    logic [15:0] octets;
  } jtp_lane_t;

endpackage

// File: logic/jtp_pattern_gen.sv
// sample pattern generator: checkerboard, toggle, pn sequences, ramp and user words
`timescale 1ns/100ps
`include "jtp_params.svh"

module jtp_pattern_gen
(
  input  wire logic          i_ref_clk,   // sample clock
  input  wire logic          i_rst_b,     // synchronous reset, active low
  input  wire logic [3:0]    i_sel,       // sample pattern select code
  input  wire logic [15:0]   i_user,      // user test word
  input  wire logic [15:0]   i_sample,    // live converter word
  output logic      [15:0]   o_word_q     // word handed to the framer
);

  // one pn bit step for polynomial x^len + x^tap + 1
  function automatic logic [30:0] pn_step(input logic [30:0] s, input int len, input int tap);
    logic fb;
    fb = s[len-1] ^ s[tap-1];
    return {s[29:0], fb};
  endfunction

  logic [30:0] pn_q;        // shared pn register
  logic [30:0] pn_d;
  logic [15:0] word_d;
  logic [3:0]  sel_q;       // previous selector, reseeds on change
  logic        single_q;    // single user word already sent
  logic        single_d;
  logic [15:0] pn_bits;

  // ***************************************************************
  // next word
  // ***************************************************************
  always_comb
  begin
    pn_d     = pn_q;
    pn_bits  = 16'h0000;
    single_d = single_q;
    word_d   = i_sample;
    if (i_sel != sel_q)
    begin
      pn_d     = `JTP_PN_SEED;
      single_d = 1'b0;
    end
    for (int i = 0; i < 16; i++)
    begin
      // pn modes advance 16 bits per word, newest bit lands lowest
      unique case (i_sel)
        4'h3:    pn_d = pn_step(pn_d, 31, 28);
        4'h4:    pn_d = pn_step(pn_d, 23, 18);
        4'h5:    pn_d = pn_step(pn_d, 15, 14);
        4'h6:    pn_d = pn_step(pn_d, 9, 5);
        4'h7:    pn_d = pn_step(pn_d, 7, 6);
        default: pn_d = pn_d;
      endcase
      pn_bits[15-i] = pn_d[0];
    end
    unique case (i_sel)
      4'h0:                   word_d = i_sample;
      4'h1:                   word_d = (o_word_q == 16'hAAAA) ? 16'h5555 : 16'hAAAA;
      4'h2:                   word_d = (o_word_q == 16'hFFFF) ? 16'h0000 : 16'hFFFF;
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7:
                              word_d = pn_bits;
      4'h8:                   word_d = o_word_q + 16'h0001;
      4'hE:                   word_d = i_user;
      4'hF:
      begin
        // user word once, then zeros until the code changes
        word_d   = single_d ? 16'h0000 : i_user;
        single_d = 1'b1;
      end
      default:                word_d = 16'h0000;
    endcase
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      pn_q     <= `JTP_PN_SEED;
      sel_q    <= 4'h0;
      single_q <= 1'b0;
      o_word_q <= 16'h0000;
    end
    else
    begin
      pn_q     <= pn_d;
      sel_q    <= i_sel;
      single_q <= single_d;
      o_word_q <= word_d;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  a_normal_pass: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_sel == 4'h0) |=> (o_word_q == $past(i_sample)))
    else $error("normal mode did not pass the sample");
  a_checker_alt: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_sel == 4'h1) ##1 (i_sel == 4'h1) |=> (o_word_q == ~$past(o_word_q)))
    else $error("checkerboard did not alternate");
  a_ramp_step: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_sel == 4'h8) |=> (o_word_q == $past(o_word_q) + 16'h0001))
    else $error("ramp did not step by one");
  a_pn_alive: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_sel == 4'h7) [*3] |-> (pn_q[6:0] != 7'h00))
    else $error("pn register stuck at zero");
  c_pn31_run: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) (i_sel == 4'h3) [*4]);

endmodule

// File: tb/jtp_rx_model.sv
// receiver model that paces the sync request from the comma stream
`timescale 1ns/100ps
`include "jtp_params.svh"
module jtp_rx_model
(
  input  wire logic               i_ref_clk,       // sample clock
  input  wire logic               i_rst_b,         // synchronous reset, active low
  input  wire logic               i_hold,          // bench keeps sync requested
  input  wire jtp_pkg::jtp_lane_t i_lane,          // transmitter lane
  output logic                    o_sync_request_b // sync request, active low
);
  logic [2:0] run_q; // comma pairs seen in a row
  logic       rel_q; // sync released
  // release after four comma pairs; request again whenever held
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b || i_hold)
    begin
      run_q <= 3'h0;
      rel_q <= 1'b0;
    end
    else if (run_q == 3'h4)
      rel_q <= 1'b1;
    else if (i_lane === {2'h3, `JTP_K28_5, `JTP_K28_5})
      run_q <= run_q + 3'h1;
    else
      run_q <= 3'h0;
  end
  assign o_sync_request_b = rel_q;
endmodule

// File: tb/test_jtp_tx_test_align.sv
// self-checking bench for the test pattern and alignment block
`timescale 1ns/100ps
`include "jtp_params.svh"
module test_jtp_tx_test_align;
  logic               clk, rst_b, rd, wr, sysref, hold;
  logic               sync_b, wreq, mfb;
  logic        [12:0] adr;
  logic        [31:0] wdat, rdat, rdata;
  logic        [15:0] smp;
  logic        [15:0] w [16];
  logic        [3:0]  pc [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 14, 15, 0};
  jtp_pkg::jtp_lane_t lane;
  int                 n_fail, cmp_count, cyc, nb;
  jtp_tx_test_align i_dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_sync_request_b(sync_b), .i_sysref(sysref), .i_sample(smp),
    .o_lane_q(lane), .o_mf_boundary_q(mfb));
  jtp_rx_model i_rx (.i_ref_clk(clk), .i_rst_b(rst_b), .i_hold(hold), .i_lane(lane), .o_sync_request_b(sync_b));
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // verdict and end of run
  task summarize;
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      summarize();
    end
  end
  // one bus transfer, held until waitrequest is seen low
  task bus(input logic [10:0] idx, input logic we, input logic [7:0] d);
    @(posedge clk);
    adr <= {idx, 2'h0};
    rd <= ~we;
    wr <= we;
    wdat <= {24'h0, d};
    // the answer edge is the rising edge at which waitrequest is sampled low
    do @(posedge clk); while (wreq !== 1'b0);
    rdat = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // sixteen lane words, one per cycle
  task grab;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 16; i++) begin @(posedge clk); #1 w[i] = lane.octets; end
  endtask
  // pn recurrence b[n] = b[n-a] ^ b[n-b] over 64 bits, first bit in bit 15
  function automatic logic pn_ok(input int a, input int b);
    logic [63:0] s;
    logic        ok;
    s = {w[0], w[1], w[2], w[3]};
    ok = 1'b1;
    for (int n = 31; n < 64; n++) if (s[63-n] !== (s[63-n+a] ^ s[63-n+b])) ok = 1'b0;
    return ok;
  endfunction
  function automatic logic pat_ok(input logic [3:0] c);
    case (c)
      4'h0: return w[0] === smp;
      4'h1: return (w[0] === 16'hAAAA || w[0] === 16'h5555) && w[1] === ~w[0];
      4'h2: return (w[0] === 16'hFFFF || w[0] === 16'h0000) && w[1] === ~w[0];
      4'h3: return pn_ok(31, 28);
      4'h4: return pn_ok(23, 18);
      4'h5: return pn_ok(15, 14);
      4'h6: return pn_ok(9, 5);
      4'h7: return pn_ok(7, 6);
      4'h8: return w[1] === w[0] + 16'h1;
      4'hE: return w[0] === 16'h1234 && w[5] === 16'h1234;
      default: return w[0] === 16'h0 && w[5] === 16'h0;
    endcase
  endfunction
  initial
  begin
    {rst_b, rd, wr, adr, wdat, sysref, n_fail, cmp_count, cyc} = '0;
    hold = 1'b1;
    smp = 16'hC3A5;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    bus(`JTP_IDX_LINK_CTRL, 0, 0); chk(rdat, 0);
    bus(`JTP_IDX_PAT_SEL, 0, 0); chk(rdat, 0);
    bus(`JTP_IDX_MF_FRAMES, 0, 0); chk(rdat, 32'h1F);
    bus(`JTP_IDX_LINK_CTRL, 1, 8'hFF); bus(`JTP_IDX_LINK_CTRL, 0, 0); chk(rdat, 32'hF7);
    bus(11'h100, 1, 8'h55); bus(11'h100, 0, 0); chk(rdat, 0);
    bus(`JTP_IDX_LINK_CTRL, 1, 8'hF0);
    bus(`JTP_IDX_MF_FRAMES, 1, 8'h03);
    bus(`JTP_IDX_MF_PRESET, 1, 8'h02);
    bus(`JTP_IDX_USER_LO, 1, 8'h34);
    bus(`JTP_IDX_USER_HI, 1, 8'h12);
    // preset 2 with four-cycle multiframes: marker two edges after the pulse
    @(posedge clk) sysref <= 1'b1;
    @(posedge clk) sysref <= 1'b0;
    @(posedge clk) #1 chk(mfb, 0);
    @(posedge clk) #1 chk(mfb, 1);
    chk(lane, {2'h3, `JTP_K28_5, `JTP_K28_5});
    // release right after a boundary, then count boundaries up to the alignment start
    while (mfb !== 1'b1) @(posedge clk) #1;
    repeat (2) @(posedge clk);
    hold <= 1'b0;
    // count only boundaries that fall once the link waits, one edge after the release is sampled
    do @(posedge clk) #1; while (sync_b !== 1'b1);
    repeat (2) @(posedge clk);
    nb = 0;
    repeat (90) begin #1; if (lane.k[1] && lane.octets[15:8] == `JTP_K28_0) break; nb += mfb; @(posedge clk); end
    chk(nb, 16);
    repeat (20) @(posedge clk);
    // status: data state, sync released, boundary count held at fifteen
    bus(`JTP_IDX_STATUS, 0, 0);
    chk(rdat[7:0], 8'hF7);
    foreach (pc[i])
    begin
      bus(`JTP_IDX_PAT_SEL, 1, {4'h0, pc[i]});
      // the single user word shows once, two edges after the write lands
      if (pc[i] == 4'hF)
      begin
        repeat (2) @(posedge clk);
        #1 chk(lane.octets, 16'h1234);
      end
      grab();
      chk(pat_ok(pc[i]), 1);
    end
    for (int c = 0; c < 8; c++)
    begin
      bus(`JTP_IDX_LINK_CTRL, 1, 8'(c)); bus(`JTP_IDX_LINK_CTRL, 0, 0); chk(rdat, c);
      grab();
      if (c == 1) chk(w[0], {`JTP_D21_5, `JTP_D21_5});
      else if (c > 3 && c < 7) chk({w[0], w[1]}, {w[8], w[9]});
      else chk(w[0], smp);
    end
    summarize();
  end
endmodule
